/* hdl/port_set_params.svh */
// constants for the open-drain port set: widths, reset values, pin indices
`ifndef PORT_SET_PARAMS_SVH
`define PORT_SET_PARAMS_SVH

// port widths
`define QUAD_WIDTH        4
`define DUAL_WIDTH        2
`define BITPORT_LINES     4
`define ACC_WIDTH         4

// output latches come up released (high impedance)
`define QUAD_LATCH_RESET  4'hf
`define DUAL_LATCH_RESET  2'h3
`define BIT_LATCH_RESET   1'h1

// control register reset values
`define WAKE_RESET        4'h0
`define PULL_RESET        4'h0

// index of the counter pin on the second quad port
`define COUNTER_PIN_BIT   2
// index of the shared lines within port D
`define SHARED_C_LINE     2
`define SHARED_K_LINE     3

`endif

/* hdl/port_set_pkg.sv */
// types shared by the open-drain port set
package port_set_pkg;

  // instruction codes offered by the executor
  typedef enum logic [4:0]
  {
    op_none,
    read_quad_zero_to_acc,
    write_quad_zero_from_acc,
    read_quad_one_to_acc,
    write_quad_one_from_acc,
    read_dual_to_acc,
    write_dual_from_acc,
    bitport_latch_set,
    bitport_latch_clear,
    bitport_all_release,
    bitport_zero_skip,
    shared_bit_set,
    shared_bit_clear,
    shared_bit_one_skip,
    single_port_write,
    single_port_read,
    wake_q0_write,
    wake_q0_read,
    pull_q0_write,
    wake_q1_write,
    wake_q1_read,
    pull_q1_write,
    wake_aux_write,
    wake_aux_read,
    pull_aux_write
  } port_op_t;

endpackage

/* hdl/open_drain_port_set.sv */
// open-drain port set: quad, dual, port D, port C and port K logic
`timescale 1ns/1ps
`include "port_set_params.svh"

module open_drain_port_set
  import port_set_pkg::*;
#(
  parameter int QW = `QUAD_WIDTH,      // quad port width
  parameter int DW = `DUAL_WIDTH       // dual port width
)
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // instruction executor side
  input  wire port_set_pkg::port_op_t op_code,
  input  wire logic [3:0]            acc_in,
  input  wire logic [3:0]            bitport_select,
  input  wire logic                  counter_pin_select_bit,
  output logic      [3:0]            acc_out,
  output logic                       acc_load,
  output logic                       skip_next,
  // quad port zero pins
  input  wire logic [QW-1:0]         quad_port_zero_i,
  output logic      [QW-1:0]         quad_port_zero_o,
  output logic      [QW-1:0]         quad_port_zero_oe_n,
  // quad port one pins
  input  wire logic [QW-1:0]         quad_port_one_i,
  output logic      [QW-1:0]         quad_port_one_o,
  output logic      [QW-1:0]         quad_port_one_oe_n,
  // dual bit port pins
  input  wire logic [DW-1:0]         dual_bit_port_i,
  output logic      [DW-1:0]         dual_bit_port_o,
  output logic      [DW-1:0]         dual_bit_port_oe_n,
  // port D lines 0 and 1
  input  wire logic [1:0]            bitport_pin_i,
  output logic      [1:0]            bitport_pin_o,
  output logic      [1:0]            bitport_pin_oe_n,
  // shared pin D2 / port C
  input  wire logic                  shared_c_pin_i,
  output logic                       shared_c_pin_o,
  output logic                       shared_c_pin_oe_n,
  // shared pin D3 / port K
  input  wire logic                  shared_k_pin_i,
  output logic                       shared_k_pin_o,
  output logic                       shared_k_pin_oe_n,
  // wakeup and pullup selections
  output logic      [QW-1:0]         wakeup_enable_quad_zero,
  output logic      [QW-1:0]         pullup_enable_quad_zero,
  output logic      [QW-1:0]         wakeup_enable_quad_one,
  output logic      [QW-1:0]         pullup_enable_quad_one,
  output logic      [3:0]            wakeup_enable_aux,
  output logic      [3:0]            pullup_enable_aux
);

  import port_set_pkg::*;

  // output latches
  logic [QW-1:0] quad_zero_latch_reg;      // quad zero latches
  logic [QW-1:0] quad_one_latch_reg;       // quad one latches
  logic [DW-1:0] dual_latch_reg;           // dual port latches
  logic [3:0]    bitport_latch_reg;        // port D latches
  logic [3:0]    bitport_latch_next;       // port D next value
  logic          shared_c_latch_reg;       // port C latch
  logic          shared_c_latch_next;      // port C next value
  logic          single_latch_reg;         // port K latch
  logic          single_latch_next;        // port K next value
  // pin level of the selected port D line
  logic          bitport_sel_level;
  logic          sel_in_range;             // Y within the four lines
  // constant low drive level for every open-drain pin
  logic [13:0]   drive_level_reg;

  assign sel_in_range = (bitport_select < 4'h4);

  // port D selected line level, D2/D3 read their shared pins
  always_comb
  begin
    case (bitport_select[1:0])
      2'h0:    bitport_sel_level = bitport_pin_i[0];
      2'h1:    bitport_sel_level = bitport_pin_i[1];
      2'h2:    bitport_sel_level = shared_c_pin_i;
      default: bitport_sel_level = shared_k_pin_i;
    endcase
  end

  // next values of the single-bit latches
  always_comb
  begin
    bitport_latch_next  = bitport_latch_reg;
    shared_c_latch_next = shared_c_latch_reg;
    single_latch_next   = single_latch_reg;
    case (op_code)
      bitport_latch_set:
      begin
        if (sel_in_range)
          bitport_latch_next[bitport_select[1:0]] = 1'b1;
      end
      bitport_latch_clear:
      begin
        if (sel_in_range)
          bitport_latch_next[bitport_select[1:0]] = 1'b0;
      end
      bitport_all_release: bitport_latch_next  = 4'hf;
      shared_bit_set:      shared_c_latch_next = 1'b1;
      shared_bit_clear:    shared_c_latch_next = 1'b0;
      single_port_write:   single_latch_next   = acc_in[0];
      default:             ;
    endcase
  end

  // constant low level behind every open-drain output
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      drive_level_reg <= 14'h0000;
    else
      drive_level_reg <= 14'h0000;
  end

  assign quad_port_zero_o = drive_level_reg[3:0];
  assign quad_port_one_o  = drive_level_reg[7:4];
  assign dual_bit_port_o  = drive_level_reg[9:8];
  assign bitport_pin_o    = drive_level_reg[11:10];
  assign shared_c_pin_o   = drive_level_reg[12];
  assign shared_k_pin_o   = drive_level_reg[13];

  // quad and dual port latches
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quad_zero_latch_reg <= `QUAD_LATCH_RESET;
      quad_one_latch_reg  <= `QUAD_LATCH_RESET;
      dual_latch_reg      <= `DUAL_LATCH_RESET;
    end
    else
    begin
      if (op_code == write_quad_zero_from_acc)
        quad_zero_latch_reg <= acc_in[QW-1:0];
      if (op_code == write_quad_one_from_acc)
        quad_one_latch_reg <= acc_in[QW-1:0];
      if (op_code == write_dual_from_acc)
        dual_latch_reg <= acc_in[DW-1:0];
    end
  end

  // port D, C and K latches
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bitport_latch_reg  <= 4'hf;
      shared_c_latch_reg <= `BIT_LATCH_RESET;
      single_latch_reg   <= `BIT_LATCH_RESET;
    end
    else
    begin
      bitport_latch_reg  <= bitport_latch_next;
      shared_c_latch_reg <= shared_c_latch_next;
      single_latch_reg   <= single_latch_next;
    end
  end

  // pin enables: latch 0 drives low except the counter pin while selected, shared pins low if either owner is 0
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      quad_port_zero_oe_n <= `QUAD_LATCH_RESET;
      quad_port_one_oe_n  <= `QUAD_LATCH_RESET;
      dual_bit_port_oe_n  <= `DUAL_LATCH_RESET;
      bitport_pin_oe_n    <= 2'h3;
      shared_c_pin_oe_n   <= 1'b1;
      shared_k_pin_oe_n   <= 1'b1;
    end
    else
    begin
      quad_port_zero_oe_n <= (op_code == write_quad_zero_from_acc) ? acc_in[QW-1:0]
                                                                   : quad_zero_latch_reg;
      quad_port_one_oe_n  <= (op_code == write_quad_one_from_acc) ? acc_in[QW-1:0]
                                                                  : quad_one_latch_reg;
      // counter function owns the pin while selected
      if (counter_pin_select_bit)
        quad_port_one_oe_n[`COUNTER_PIN_BIT] <= 1'b1;
      dual_bit_port_oe_n  <= (op_code == write_dual_from_acc) ? acc_in[DW-1:0] : dual_latch_reg;
      bitport_pin_oe_n    <= bitport_latch_next[1:0];
      shared_c_pin_oe_n   <= bitport_latch_next[`SHARED_C_LINE] & shared_c_latch_next;
      shared_k_pin_oe_n   <= bitport_latch_next[`SHARED_K_LINE] & single_latch_next;
    end
  end

  // wakeup and pullup control registers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wakeup_enable_quad_zero <= `WAKE_RESET;
      pullup_enable_quad_zero <= `PULL_RESET;
      wakeup_enable_quad_one  <= `WAKE_RESET;
      pullup_enable_quad_one  <= `PULL_RESET;
      wakeup_enable_aux       <= `WAKE_RESET;
      pullup_enable_aux       <= `PULL_RESET;
    end
    else
    begin
      case (op_code)
        wake_q0_write:  wakeup_enable_quad_zero <= acc_in[QW-1:0];
        pull_q0_write:  pullup_enable_quad_zero <= acc_in[QW-1:0];
        wake_q1_write:  wakeup_enable_quad_one  <= acc_in[QW-1:0];
        pull_q1_write:  pullup_enable_quad_one  <= acc_in[QW-1:0];
        wake_aux_write: wakeup_enable_aux       <= acc_in;
        pull_aux_write: pullup_enable_aux       <= acc_in;
        default:        ;
      endcase
    end
  end

  // accumulator reads, one-cycle load strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_out  <= 4'h0;
      acc_load <= 1'b0;
    end
    else
    begin
      acc_load <= 1'b1;
      case (op_code)
        read_quad_zero_to_acc: acc_out <= quad_port_zero_i;
        read_quad_one_to_acc:  acc_out <= quad_port_one_i;
        read_dual_to_acc:      acc_out <= {2'h0, dual_bit_port_i};
        single_port_read:      acc_out <= {3'h0, shared_k_pin_i};
        wake_q0_read:          acc_out <= wakeup_enable_quad_zero;
        wake_q1_read:          acc_out <= wakeup_enable_quad_one;
        wake_aux_read:         acc_out <= wakeup_enable_aux;
        default:               acc_load <= 1'b0;
      endcase
    end
  end

  // skip decisions for the two test instructions
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      skip_next <= 1'b0;
    else if (op_code == bitport_zero_skip)
      skip_next <= sel_in_range & ~bitport_sel_level;
    else if (op_code == shared_bit_one_skip)
      skip_next <= shared_c_pin_i;
    else
      skip_next <= 1'b0;
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence q0_read_seq;
    op_code == read_quad_zero_to_acc ##1 acc_load;
  endsequence

  quad_zero_read_a: assert property (q0_read_seq |-> acc_out == $past(quad_port_zero_i))
    else $error("quad zero read wrong");
  quad_zero_write_a: assert property (op_code == write_quad_zero_from_acc
      |=> quad_port_zero_oe_n == $past(acc_in[QW-1:0]) && quad_zero_latch_reg == $past(acc_in[QW-1:0]))
    else $error("quad zero write wrong");
  dual_read_a: assert property (op_code == read_dual_to_acc
      |=> acc_load && acc_out == {2'h0, $past(dual_bit_port_i)})
    else $error("dual read wrong");
  single_read_a: assert property (op_code == single_port_read
      |=> acc_out[3:1] == 3'h0 && acc_out[0] == $past(shared_k_pin_i))
    else $error("single read wrong");
  bitport_skip_a: assert property (op_code == bitport_zero_skip && sel_in_range
      |=> skip_next == !$past(bitport_sel_level)
      ##1 !skip_next || $past(op_code) inside {bitport_zero_skip, shared_bit_one_skip})
    else $error("port D skip wrong");
  shared_skip_a: assert property (op_code == shared_bit_one_skip |=> skip_next == $past(shared_c_pin_i))
    else $error("port C skip wrong");
  release_all_a: assert property (op_code == bitport_all_release
      |=> bitport_latch_reg == 4'hf && bitport_pin_oe_n == 2'h3)
    else $error("release all wrong");
  shared_pin_a: assert property (##1 shared_c_pin_oe_n == (bitport_latch_reg[2] & shared_c_latch_reg)
      && shared_k_pin_oe_n == (bitport_latch_reg[3] & single_latch_reg))
    else $error("shared pin drive wrong");
  counter_pin_a: assert property (counter_pin_select_bit |=> quad_port_one_oe_n[2])
    else $error("counter pin driven");
  clear_line_a: assert property (op_code == bitport_latch_clear && bitport_select == 4'h1
      |=> !bitport_pin_oe_n[1] && bitport_latch_reg[1] == 1'b0)
    else $error("port D clear wrong");

  // further checks on reads, writes, refused selects and idle pulses
  quad_one_read_a: assert property (op_code == read_quad_one_to_acc
      |=> acc_load && acc_out == $past(quad_port_one_i))
    else $error("quad one read wrong");
  quad_one_write_a: assert property (op_code == write_quad_one_from_acc && !counter_pin_select_bit
      |=> quad_port_one_oe_n == $past(acc_in[QW-1:0]))
    else $error("quad one write wrong");
  shared_clear_a: assert property (op_code == shared_bit_clear
      |=> !shared_c_latch_reg && !shared_c_pin_oe_n)
    else $error("port C clear wrong");
  single_write_a: assert property (op_code == single_port_write
      |=> single_latch_reg == $past(acc_in[0]))
    else $error("port K write wrong");
  wake_zero_write_a: assert property (op_code == wake_q0_write
      |=> wakeup_enable_quad_zero == $past(acc_in[QW-1:0]))
    else $error("quad zero wakeup write wrong");
  aux_pull_write_a: assert property (op_code == pull_aux_write
      |=> pullup_enable_aux == $past(acc_in))
    else $error("aux pullup write wrong");
  set_line_a: assert property (op_code == bitport_latch_set && bitport_select[3:2] == 2'h0
      |=> bitport_latch_reg[$past(bitport_select[1:0])])
    else $error("port D set wrong");
  refused_select_a: assert property ((op_code == bitport_latch_set || op_code == bitport_latch_clear)
      && bitport_select[3:2] != 2'h0 |=> $stable(bitport_latch_reg))
    else $error("refused select changed latch");
  load_idle_a: assert property (op_code == op_none
      |=> !acc_load)
    else $error("load pulse without read");
  skip_idle_a: assert property (op_code != bitport_zero_skip && op_code != shared_bit_one_skip
      |=> !skip_next)
    else $error("skip pulse without test");

endmodule

/* tb/port_pin_model.sv */
// pin-side model: far-side sources on open-drain lines with pull-ups
`timescale 1ns/1ps
module port_pin_model
(
  input  wire logic [13:0] line_oe_n,  // design drive enables, low pulls down
  input  wire logic [13:0] far_pull_n, // far-side sources, low pulls down
  output logic      [13:0] line_lvl    // resolved level fed to every input
);
  // wired-and: a line nobody pulls down rests high on its pull-up
  assign line_lvl = line_oe_n & far_pull_n;
endmodule

/* tb/open_drain_port_set_tb.sv */
// self-checking bench for the open-drain port set
`timescale 1ns/1ps
module open_drain_port_set_tb;
  import port_set_pkg::*;
  logic       core_clk = 1'b0;               // bench clock
  logic       rst_n = 1'b0;                  // async reset
  port_op_t   op_code = op_none;             // instruction to the design
  logic [3:0] acc_in = 4'h0;                 // accumulator value
  logic [3:0] bitport_select = 4'h0;         // line selector
  logic       counter_pin_select_bit = 1'b0; // counter function select
  logic [13:0] far_n = 14'h3fff;             // far-side pin sources
  wire  [13:0] line_lvl;                     // resolved pin levels
  logic [3:0] acc_out, q0_o, q0_oe_n, q1_o, q1_oe_n, wq0, pq0, wq1, pq1, wa, pa;
  logic [1:0] du_o, du_oe_n, bp_o, bp_oe_n;
  logic       acc_load, skip_next, sc_o, sc_oe_n, sk_o, sk_oe_n;
  // reference state of latches and control bits
  logic [3:0] m_q0, m_q1, m_d, m_wq0, m_pq0, m_wq1, m_pq1, m_wa, m_pa;
  logic [1:0] m_du;
  logic       m_c, m_k;
  logic [31:0] seed = 32'h593c_fe9e;         // fixed random seed
  int         n_fail = 0;                    // mismatches
  int         num_checks = 0;                // comparisons made

  open_drain_port_set #(.QW(4), .DW(2)) dut_u
  (
    .core_clk(core_clk), .rst_n(rst_n), .op_code(op_code), .acc_in(acc_in),
    .bitport_select(bitport_select), .counter_pin_select_bit(counter_pin_select_bit),
    .acc_out(acc_out), .acc_load(acc_load), .skip_next(skip_next),
    .quad_port_zero_i(line_lvl[13:10]), .quad_port_zero_o(q0_o), .quad_port_zero_oe_n(q0_oe_n),
    .quad_port_one_i(line_lvl[9:6]), .quad_port_one_o(q1_o), .quad_port_one_oe_n(q1_oe_n),
    .dual_bit_port_i(line_lvl[5:4]), .dual_bit_port_o(du_o), .dual_bit_port_oe_n(du_oe_n),
    .bitport_pin_i(line_lvl[3:2]), .bitport_pin_o(bp_o), .bitport_pin_oe_n(bp_oe_n),
    .shared_c_pin_i(line_lvl[1]), .shared_c_pin_o(sc_o), .shared_c_pin_oe_n(sc_oe_n),
    .shared_k_pin_i(line_lvl[0]), .shared_k_pin_o(sk_o), .shared_k_pin_oe_n(sk_oe_n),
    .wakeup_enable_quad_zero(wq0), .pullup_enable_quad_zero(pq0),
    .wakeup_enable_quad_one(wq1), .pullup_enable_quad_one(pq1),
    .wakeup_enable_aux(wa), .pullup_enable_aux(pa)
  );

  port_pin_model pins_u
  (
    .line_oe_n({q0_oe_n, q1_oe_n, du_oe_n, bp_oe_n, sc_oe_n, sk_oe_n}),
    .far_pull_n(far_n),
    .line_lvl(line_lvl)
  );

  // 4 ns clock
  always #2 core_clk = ~core_clk;

  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // one comparison, reported on mismatch
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // reference state after reset
  task automatic model_init();
    {m_q0, m_q1, m_d, m_du, m_c, m_k} = 16'hffff;
    {m_wq0, m_pq0, m_wq1, m_pq1, m_wa, m_pa} = 24'h00_0000;
  endtask

  // compare every standing output against the reference
  task automatic check_state();
    chk("quad zero oe_n", m_q0, q0_oe_n);
    chk("quad one oe_n", m_q1 | {1'b0, counter_pin_select_bit, 2'b00}, q1_oe_n);
    chk("dual oe_n", {2'b00, m_du}, {2'b00, du_oe_n});
    chk("line oe_n", {2'b00, m_d[1:0]}, {2'b00, bp_oe_n});
    chk("shared oe_n", {2'b00, m_d[3] & m_k, m_d[2] & m_c}, {2'b00, sk_oe_n, sc_oe_n});
    chk("drive levels", 4'h0, (q0_o | q1_o) | {du_o, bp_o} | {2'b00, sk_o, sc_o});
    chk("wake zero", m_wq0, wq0);
    chk("pull zero", m_pq0, pq0);
    chk("wake one", m_wq1, wq1);
    chk("pull one", m_pq1, pq1);
    chk("wake aux", m_wa, wa);
    chk("pull aux", m_pa, pa);
  endtask

  // issue one instruction, update the reference, check one edge later
  task automatic step(input port_op_t o, input logic [3:0] a, input logic [3:0] y);
    logic [3:0] lv;
    logic [3:0] e_out;
    logic       e_ld;
    logic       e_sk;
    lv = {far_n[0] & m_d[3] & m_k, far_n[1] & m_d[2] & m_c, far_n[3:2] & m_d[1:0]};
    e_ld = o inside {read_quad_zero_to_acc, read_quad_one_to_acc, read_dual_to_acc, single_port_read,
                     wake_q0_read, wake_q1_read, wake_aux_read};
    e_sk = (o == bitport_zero_skip && y < 4'h4 && !lv[y[1:0]]) || (o == shared_bit_one_skip && lv[2]);
    case (o)
      read_quad_zero_to_acc: e_out = far_n[13:10] & m_q0;
      read_quad_one_to_acc:  e_out = far_n[9:6] & (m_q1 | {1'b0, counter_pin_select_bit, 2'b00});
      read_dual_to_acc:      e_out = {2'b00, far_n[5:4] & m_du};
      single_port_read:      e_out = {3'b000, lv[3]};
      wake_q0_read:          e_out = m_wq0;
      wake_q1_read:          e_out = m_wq1;
      default:               e_out = m_wa;
    endcase
    case (o)
      write_quad_zero_from_acc: m_q0 = a;
      write_quad_one_from_acc:  m_q1 = a;
      write_dual_from_acc:      m_du = a[1:0];
      bitport_latch_set:        if (y < 4'h4) m_d[y[1:0]] = 1'b1;
      bitport_latch_clear:      if (y < 4'h4) m_d[y[1:0]] = 1'b0;
      bitport_all_release:      m_d = 4'hf;
      shared_bit_set:           m_c = 1'b1;
      shared_bit_clear:         m_c = 1'b0;
      single_port_write:        m_k = a[0];
      wake_q0_write:            m_wq0 = a;
      pull_q0_write:            m_pq0 = a;
      wake_q1_write:            m_wq1 = a;
      pull_q1_write:            m_pq1 = a;
      wake_aux_write:           m_wa = a;
      pull_aux_write:           m_pa = a;
      default:                  ;
    endcase
    op_code = o;
    acc_in = a;
    bitport_select = y;
    @(posedge core_clk);
    #1;
    chk("acc_load", {3'b000, e_ld}, {3'b000, acc_load});
    if (e_ld)
      chk("acc_out", e_out, acc_out);
    chk("skip_next", {3'b000, e_sk}, {3'b000, skip_next});
    check_state();
  endtask

  // verdict and end of run
  task automatic results();
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hung run
  initial
  begin
    #40000;
    n_fail++;
    results();
  end

  // main sequence
  initial
  begin
    model_init();
    repeat (8) @(posedge core_clk);
    #1;
    check_state();
    chk("reset pulses", 4'h0, {2'b00, acc_load, skip_next});
    chk("acc_out reset", 4'h0, acc_out);
    rst_n = 1'b1;
    // corners: refused selector, shared-pin interlocks, back-to-back skips
    step(bitport_latch_clear, 4'h0, 4'h4);
    step(bitport_latch_clear, 4'h0, 4'h3);
    step(single_port_read, 4'h0, 4'h0);
    step(bitport_zero_skip, 4'h0, 4'h3);
    step(bitport_all_release, 4'h0, 4'h0);
    step(shared_bit_clear, 4'h0, 4'h2);
    step(bitport_zero_skip, 4'h0, 4'h2);
    step(shared_bit_one_skip, 4'h0, 4'h0);
    step(shared_bit_set, 4'h0, 4'h0);
    step(shared_bit_one_skip, 4'h0, 4'h0);
    // random traffic over every instruction code
    repeat (600)
    begin
      seed = lfsr_next(seed);
      far_n = seed[13:0];
      if (seed[31])
      begin
        counter_pin_select_bit = seed[30];
        step(op_none, 4'h0, 4'h0);
      end
      step(port_op_t'(5'(seed[21:14] % 24) + 5'h1), seed[25:22], {1'b0, seed[28:26]});
    end
    // second reset in mid-run
    op_code = op_none;
    rst_n = 1'b0;
    model_init();
    repeat (2) @(posedge core_clk);
    #1;
    check_state();
    chk("mid reset pulses", 4'h0, {2'b00, acc_load, skip_next});
    rst_n = 1'b1;
    // first instructions straight after the second release
    step(read_quad_zero_to_acc, 4'h0, 4'h0);
    step(write_quad_zero_from_acc, 4'h5, 4'h0);
    results();
  end
endmodule
